/* File: core/eac_access_control.sv */
`include "eac_defines.svh"
module eac_access_control #(
    parameter int unsigned ATOMIC_TICKS = `EAC_T_ATOMIC_NS / `EAC_TICK_NS,
    parameter int unsigned SPLIT_TICKS = `EAC_T_SPLIT_NS / `EAC_TICK_NS
) (
    // Clock and resets
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic porst_n,
    // Processor I/O access
    input wire eac_pkg::eac_bus_req_s busReq,
    output logic [7:0] busRdata,
    // Processor control
    input wire logic gie,
    output logic cpuStall,
    output logic readyIrq
);
    logic rstSync1;
    logic rstSync2;
    logic ioHit;
    logic [5:0] ioAddr;
    logic bitOp;
    logic wrEn;
    logic [7:0] wrMask;
    logic [7:0] wrVal;
    logic selCtl;
    logic selData;
    logic selAddrLow;
    logic selScratch0;
    logic selScratch1;
    logic [7:0] ctlRead;
    logic [7:0] ctlNew;
    logic [7:0] ctlOnes;
    logic startNow;
    logic readNow;
    logic busy;
    logic arm;
    logic [2:0] armCnt;
    logic ie;
    eac_pkg::eac_mode_t mode;
    eac_pkg::eac_mode_t newMode;
    logic [7:0] addrLow;
    logic [7:0] nvData;
    logic [7:0] scratch0;
    logic [7:0] scratch1;
    logic [7:0] arrayRd;
    logic [7:0] rdMux;
    logic [2:0] stallCnt;
    logic [2:0] next_stallCnt;
    eac_pkg::eac_op_s op;

    function automatic logic [7:0] mergeBits(input logic [7:0] old, input logic [7:0] mask,
                                             input logic [7:0] val);
        return (old & ~mask) | (val & mask);
    endfunction

    // Reset release, two stages
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    // Address decode, I/O or data space
    always_comb begin
        ioHit = 1'b0;
        ioAddr = 6'h00;
        if (busReq.dataSpace) begin
            if (busReq.addr >= `EAC_DS_OFFSET && busReq.addr < `EAC_DS_OFFSET + `EAC_IO_SPAN) begin
                ioHit = 1'b1;
                ioAddr = 6'(busReq.addr - `EAC_DS_OFFSET);
            end
        end else if (busReq.addr < `EAC_IO_SPAN) begin
            ioHit = 1'b1;
            ioAddr = busReq.addr[5:0];
        end
    end

    // Write shape: whole byte or one bit
    always_comb begin
        bitOp = (busReq.bitSet || busReq.bitClr) && !busReq.wr && !busReq.dataSpace
                && ioHit && (ioAddr <= `EAC_BITOP_TOP);
        if (bitOp) begin
            wrMask = 8'h01 << busReq.bitSel;
            wrVal = busReq.bitSet ? 8'hFF : 8'h00;
        end else begin
            wrMask = busReq.wr ? 8'hFF : 8'h00;
            wrVal = busReq.wdata;
        end
        wrEn = rstSync2 && ioHit && (busReq.wr || bitOp);
    end

    assign selCtl = wrEn && (ioAddr == `EAC_OFS_CONTROL);
    assign selData = wrEn && (ioAddr == `EAC_OFS_DATA);
    assign selAddrLow = wrEn && (ioAddr == `EAC_OFS_ADDR_LOW);
    assign selScratch0 = wrEn && (ioAddr == `EAC_OFS_SCRATCH0);
    assign selScratch1 = wrEn && (ioAddr == `EAC_OFS_SCRATCH1);

    assign ctlRead = {2'b00, mode, ie, arm, busy, 1'b0};
    assign ctlNew = mergeBits(ctlRead, wrMask, wrVal);
    assign ctlOnes = wrMask & wrVal;
    assign newMode = ctlNew[`EAC_CR_PM_HI:`EAC_CR_PM_LO];

    // Strobe acts only when armed, idle and mode is defined
    assign startNow = selCtl && ctlOnes[`EAC_CR_PE] && arm && !busy && (newMode != `EAC_MODE_RSVD);
    assign readNow = selCtl && ctlOnes[`EAC_CR_RE] && !busy && !startNow;

    assign op.mode = newMode;
    assign op.addr = addrLow;
    assign op.data = nvData;

    eac_nv_array #(
        .ATOMIC_TICKS(ATOMIC_TICKS),
        .SPLIT_TICKS(SPLIT_TICKS)
    ) u_array (
        .mclk(mclk),
        .porst_n(porst_n),
        .start(startNow),
        .op(op),
        .rdAddr(addrLow),
        .rdData(arrayRd),
        .busy(busy)
    );

    // Arm window
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            arm <= 1'b0;
            armCnt <= 3'h0;
        end else if (selCtl && wrMask[`EAC_CR_MPE]) begin
            arm <= wrVal[`EAC_CR_MPE];
            armCnt <= wrVal[`EAC_CR_MPE] ? `EAC_ARM_CYC : 3'h0;
        end else if (arm) begin
            armCnt <= armCnt - 3'h1;
            if (armCnt == 3'h1) begin
                arm <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ie <= 1'b0;
        end else if (selCtl) begin
            ie <= ctlNew[`EAC_CR_RIE];
        end
    end

    // Mode survives a reset that lands during programming
    always_ff @(posedge mclk or negedge porst_n) begin
        if (!porst_n) begin
            mode <= `EAC_MODE_RST;
        end else if (!rstSync2 && !busy) begin
            mode <= `EAC_MODE_RST;
        end else if (selCtl && !busy) begin
            mode <= newMode;
        end
    end

    always_ff @(posedge mclk or negedge porst_n) begin
        if (!porst_n) begin
            addrLow <= `EAC_ADDR_RST;
        end else if (selAddrLow && !busy) begin
            addrLow <= mergeBits(addrLow, wrMask, wrVal);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nvData <= `EAC_DATA_RST;
        end else if (readNow) begin
            nvData <= arrayRd;
        end else if (selData) begin
            nvData <= mergeBits(nvData, wrMask, wrVal);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scratch0 <= `EAC_SCRATCH_RST;
            scratch1 <= `EAC_SCRATCH_RST;
        end else begin
            if (selScratch0) begin
                scratch0 <= mergeBits(scratch0, wrMask, wrVal);
            end
            if (selScratch1) begin
                scratch1 <= mergeBits(scratch1, wrMask, wrVal);
            end
        end
    end

    // Processor stall
    always_comb begin
        next_stallCnt = (stallCnt != 3'h0) ? stallCnt - 3'h1 : 3'h0;
        if (startNow) begin
            next_stallCnt = `EAC_STALL_WR;
        end else if (readNow) begin
            next_stallCnt = `EAC_STALL_RD;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stallCnt <= 3'h0;
            cpuStall <= 1'b0;
        end else begin
            stallCnt <= next_stallCnt;
            cpuStall <= (next_stallCnt != 3'h0);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            readyIrq <= 1'b0;
        end else begin
            readyIrq <= ie && gie && !busy && !startNow;
        end
    end

    // Read data
    always_comb begin
        rdMux = 8'h00;
        if (ioHit) begin
            case (ioAddr)
                `EAC_OFS_SCRATCH0: rdMux = scratch0;
                `EAC_OFS_SCRATCH1: rdMux = scratch1;
                `EAC_OFS_CONTROL: rdMux = ctlRead;
                `EAC_OFS_DATA: rdMux = nvData;
                `EAC_OFS_ADDR_LOW: rdMux = addrLow;
                `EAC_OFS_ADDR_HIGH: rdMux = 8'h00;
                default: rdMux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busRdata <= 8'h00;
        end else if (busReq.rd) begin
            busRdata <= rdMux;
        end
    end

    // Checks
    logic [16:0] busyLen;
    logic startAtomic;
    logic [16:0] expLen;

    always_ff @(posedge mclk or negedge porst_n) begin
        if (!porst_n) begin
            busyLen <= 17'h00000;
            startAtomic <= 1'b0;
        end else if (startNow) begin
            busyLen <= 17'h00000;
            startAtomic <= (newMode == `EAC_MODE_ATOMIC);
        end else if (busy) begin
            busyLen <= busyLen + 17'h00001;
        end
    end

    assign expLen = startAtomic ? 17'(ATOMIC_TICKS * `EAC_TICK_CYC) : 17'(SPLIT_TICKS * `EAC_TICK_CYC);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n || !porst_n);

    property p_arm_window;
        (selCtl && ctlOnes[`EAC_CR_MPE]) ##1 (!selCtl)[*5] |-> $past(arm, 4) && !arm;
    endproperty
    a_arm_window: assert property (p_arm_window) else $error("arm bit not cleared after four cycles");

    property p_start;
        (selCtl && ctlOnes[`EAC_CR_PE] && arm && !busy && newMode != `EAC_MODE_RSVD) |=> busy ##1 busy;
    endproperty
    a_start: assert property (p_start) else $error("armed strobe did not start programming");

    property p_no_start;
        (selCtl && ctlOnes[`EAC_CR_PE] && !arm && !busy) |=> !busy;
    endproperty
    a_no_start: assert property (p_no_start) else $error("unarmed strobe started programming");

    property p_duration;
        $fell(busy) |-> (busyLen == expLen);
    endproperty
    a_duration: assert property (p_duration) else $error("programming time wrong for mode");

    property p_strobe_read;
        (busReq.rd && ioHit && ioAddr == `EAC_OFS_CONTROL) |=> (busRdata[`EAC_CR_PE] == $past(busy));
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("strobe bit does not show busy");

    property p_mode_locked;
        (busy && selCtl) |=> (mode == $past(mode));
    endproperty
    a_mode_locked: assert property (p_mode_locked) else $error("mode changed while busy");

    property p_mode_reset;
        (!rstSync2 && !busy) |=> (mode == `EAC_MODE_RST);
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not cleared by reset");

    property p_stall_wr;
        startNow |=> cpuStall[*2] ##1 !cpuStall;
    endproperty
    a_stall_wr: assert property (p_stall_wr) else $error("write stall not two cycles");

    property p_read_data;
        readNow |=> (nvData == $past(arrayRd));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not loaded");

    property p_stall_rd;
        (readNow && stallCnt == 3'h0) |=> cpuStall[*4] ##1 !cpuStall;
    endproperty
    a_stall_rd: assert property (p_stall_rd) else $error("read stall not four cycles");

    property p_addr_hold;
        busy |=> (addrLow == $past(addrLow)) && !$past(readNow);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address or read moved while busy");

    property p_irq;
        (ie && gie && !busy)[*2] |-> readyIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("ready interrupt missing");

    property p_irq_busy;
        busy |=> !readyIrq;
    endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("ready interrupt while busy");

    property p_high_zero;
        (busReq.rd && ioHit && ioAddr == `EAC_OFS_ADDR_HIGH) |=> (busRdata == 8'h00);
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high address not zero");

    property p_ctl_top;
        (busReq.rd && ioHit && ioAddr == `EAC_OFS_CONTROL) |=> (busRdata[7:6] == 2'b00);
    endproperty
    a_ctl_top: assert property (p_ctl_top) else $error("control top bits not zero");

    property p_bit_only;
        (bitOp && ioAddr == `EAC_OFS_SCRATCH1) |=> ((scratch1 ^ $past(scratch1)) & ~$past(wrMask)) == 8'h00;
    endproperty
    a_bit_only: assert property (p_bit_only) else $error("bit op touched other bits");

    property p_scratch;
        (busReq.wr && selScratch1) |=> (scratch1 == $past(busReq.wdata));
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch lost data");

    c_program: cover property ($fell(busy));
    c_read: cover property (readNow ##2 busReq.rd);
    c_arm_expire: cover property ($fell(arm) && !busy);
    c_bitop: cover property (bitOp && selCtl);
endmodule // eac_access_control

/* File: core/eac_defines.svh */
`ifndef EAC_DEFINES_SVH
`define EAC_DEFINES_SVH
// Overview of operation
// - Arm bit clears itself four clock cycles after software sets it.
// - Strobe written while armed, idle and in a defined mode starts programming at the current address.
// - Strobe written while unarmed is ignored; nothing is programmed.
// - Mode 00 erase+write 3.4 ms; 01 erase, 10 write 1.8 ms; 11 reserved.
// - Strobe bit stays set while busy; hardware clears it when done.
// - Mode field writes are ignored while the strobe bit is set.
// - Reset returns the mode field to 00 unless programming is busy.
// - Setting the strobe stalls the processor for two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - A read strobe stalls the processor for four cycles.
// - While busy, reads are refused and the address cannot change.
// - Ready enable plus global enable give a level interrupt while ready.
// - Data register supplies write data and receives read data.
// - High address register reads zero on this 256-byte variant.
// - Control register top two bits read zero.
// - Programming in progress at reset still completes.
// - Bit set and clear on low I/O addresses touch only that bit.
// - Data-space access sees each I/O address shifted up by 0x20.
// - Scratch registers store and return any byte, reset to zero.
// - Programming time comes from the calibrated oscillator time base.

// I/O offsets
`define EAC_OFS_SCRATCH0 6'h13
`define EAC_OFS_SCRATCH1 6'h14
`define EAC_OFS_CONTROL 6'h1C
`define EAC_OFS_DATA 6'h1D
`define EAC_OFS_ADDR_LOW 6'h1E
`define EAC_OFS_ADDR_HIGH 6'h1F
`define EAC_BITOP_TOP 6'h1F
`define EAC_DS_OFFSET 8'h20
`define EAC_IO_SPAN 8'h40

// Control register fields
`define EAC_CR_RE 0
`define EAC_CR_PE 1
`define EAC_CR_MPE 2
`define EAC_CR_RIE 3
`define EAC_CR_PM_LO 4
`define EAC_CR_PM_HI 5

// Mode encodings
`define EAC_MODE_ATOMIC 2'h0
`define EAC_MODE_ERASE 2'h1
`define EAC_MODE_WRITE 2'h2
`define EAC_MODE_RSVD 2'h3

// Reset values and erased cell value
`define EAC_SCRATCH_RST 8'h00
`define EAC_DATA_RST 8'h00
`define EAC_ADDR_RST 8'h00
`define EAC_MODE_RST 2'h0
`define EAC_ERASED 8'hFF

// Timing
`define EAC_ARM_CYC 3'h4
`define EAC_STALL_WR 3'h2
`define EAC_STALL_RD 3'h4
`define EAC_MCLK_NS 50
`define EAC_TICK_NS 1000
`define EAC_TICK_CYC (`EAC_TICK_NS / `EAC_MCLK_NS)
`define EAC_T_ATOMIC_NS 3400000
`define EAC_T_SPLIT_NS 1800000

`endif

/* File: core/eac_pkg.sv */
package eac_pkg;
    typedef logic [1:0] eac_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic dataSpace;
        logic wr;
        logic rd;
        logic bitSet;
        logic bitClr;
        logic [2:0] bitSel;
        logic [7:0] wdata;
    } eac_bus_req_s;

    typedef struct packed {
        eac_mode_t mode;
        logic [7:0] addr;
        logic [7:0] data;
    } eac_op_s;

    typedef enum logic {ENG_IDLE, ENG_BUSY} eac_eng_e;
endpackage

/* File: core/eac_nv_array.sv */
`include "eac_defines.svh"
module eac_nv_array #(
    parameter int unsigned ATOMIC_TICKS = `EAC_T_ATOMIC_NS / `EAC_TICK_NS,
    parameter int unsigned SPLIT_TICKS = `EAC_T_SPLIT_NS / `EAC_TICK_NS
) (
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic porst_n,
    // Operation request
    input wire logic start,
    input wire eac_pkg::eac_op_s op,
    // Read port
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData,
    // Status
    output logic busy
);
    logic [7:0] cells [256];
    eac_pkg::eac_eng_e state;
    eac_pkg::eac_op_s held;
    logic [4:0] divCnt;
    logic [11:0] tickCnt;
    logic tick;
    logic finish;

    function automatic logic [7:0] cellValue(input logic [7:0] old, input eac_pkg::eac_op_s o);
        unique case (o.mode)
            `EAC_MODE_ATOMIC: return o.data;
            `EAC_MODE_ERASE: return `EAC_ERASED;
            default: return old & o.data;
        endcase
    endfunction

    assign rdData = cells[rdAddr];
    assign busy = (state == eac_pkg::ENG_BUSY);
    assign tick = (divCnt == 5'(`EAC_TICK_CYC - 1));
    assign finish = busy && tick && (tickCnt == 12'h001);

    // Oscillator time base, restarted with each operation
    always_ff @(posedge mclk or negedge porst_n) begin
        if (!porst_n) begin
            divCnt <= 5'h00;
        end else if (!busy || tick) begin
            divCnt <= 5'h00;
        end else begin
            divCnt <= divCnt + 5'h01;
        end
    end

    // Runs on power-on reset only, so a system reset lets it finish
    always_ff @(posedge mclk or negedge porst_n) begin
        if (!porst_n) begin
            state <= eac_pkg::ENG_IDLE;
            tickCnt <= 12'h000;
            held <= '0;
        end else begin
            unique case (state)
                eac_pkg::ENG_IDLE: begin
                    if (start) begin
                        state <= eac_pkg::ENG_BUSY;
                        held <= op;
                        tickCnt <= (op.mode == `EAC_MODE_ATOMIC) ? 12'(ATOMIC_TICKS) : 12'(SPLIT_TICKS);
                    end
                end
                eac_pkg::ENG_BUSY: begin
                    if (tick) begin
                        tickCnt <= tickCnt - 12'h001;
                    end
                    if (finish) begin
                        state <= eac_pkg::ENG_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (finish) begin
            cells[held.addr] <= cellValue(cells[held.addr], held);
        end
    end
endmodule // eac_nv_array

/* File: test/eac_cpu.sv */
`include "eac_defines.svh"
module eac_cpu (
    // Clock
    input wire logic mclk,
    // Register bus
    output eac_pkg::eac_bus_req_s busReq,
    input wire logic [7:0] busRdata,
    // Core status
    output logic gie
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rie = 1'b1;

    initial begin
        busReq = '0;
        gie = 1'b0;
    end

    // Kind 0 write, 1 read, 2 bit set, 3 bit clear
    task automatic access(input logic [1:0] kind, input logic ds, input logic [5:0] a,
                          input logic [7:0] v, output logic [7:0] d);
        eac_pkg::eac_bus_req_s r;
        r = '0;
        r.addr = ds ? {2'h0, a} + `EAC_DS_OFFSET : {2'h0, a};
        r.dataSpace = ds;
        r.wr = kind == 2'h0;
        r.rd = kind == 2'h1;
        r.bitSet = kind == 2'h2;
        r.bitClr = kind == 2'h3;
        r.bitSel = v[2:0];
        r.wdata = v;
        @(posedge mclk);
        busReq <= r;
        @(posedge mclk);
        busReq <= '0;
        #1;
        d = busRdata;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        logic [7:0] d;
        access(2'h0, 1'b0, a, v, d);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        access(2'h1, 1'b0, a, 8'h00, d);
    endtask

    task automatic setb(input logic [5:0] a, input int b);
        logic [7:0] d;
        access(2'h2, 1'b0, a, 8'(b), d);
    endtask

    // Poll until no programming is in flight
    task automatic idle();
        logic [7:0] d;
        d = 8'hFF;
        for (int i = 0; i < 500 && d[`EAC_CR_PE] !== 1'b0; i++) begin
            rd(`EAC_OFS_CONTROL, d);
        end
    endtask

    // Address and data first, then arm, then strobe after gap idle cycles
    task automatic prog(input logic [7:0] a, input logic [7:0] v, input logic [1:0] m, input int gap);
        idle();
        wr(`EAC_OFS_ADDR_LOW, a);
        wr(`EAC_OFS_DATA, v);
        wr(`EAC_OFS_CONTROL, {2'h0, m, rie, 3'h0});
        setb(`EAC_OFS_CONTROL, `EAC_CR_MPE);
        repeat (gap) @(posedge mclk);
        setb(`EAC_OFS_CONTROL, `EAC_CR_PE);
    endtask

    task automatic nvrd(input logic [7:0] a, output logic [7:0] d);
        idle();
        wr(`EAC_OFS_ADDR_LOW, a);
        setb(`EAC_OFS_CONTROL, `EAC_CR_RE);
        rd(`EAC_OFS_DATA, d);
    endtask

    task automatic irq(input logic g);
        @(posedge mclk);
        gie <= g;
    endtask
endmodule // eac_cpu

/* File: test/eac_access_control_tb_top.sv */
`include "eac_defines.svh"
module eac_access_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned AT = 3;
    localparam int unsigned ST = 2;
    logic mclk;
    logic arstN;
    logic porstN;
    eac_pkg::eac_bus_req_s busReq;
    logic [7:0] busRdata;
    logic gie;
    logic cpuStall;
    logic readyIrq;
    int failures = 0;
    int numChecks = 0;
    int stallCur = 0;
    int stallLen = 0;
    logic [7:0] d;

    eac_access_control #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) u_eac_access_control (
        .mclk(mclk), .arst_n(arstN), .porst_n(porstN), .busReq(busReq),
        .busRdata(busRdata), .gie(gie), .cpuStall(cpuStall), .readyIrq(readyIrq));
    eac_cpu u_eac_cpu (.mclk(mclk), .busReq(busReq), .busRdata(busRdata), .gie(gie));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Length of the latest stall burst
    always @(posedge mclk) begin
        stallLen <= (cpuStall !== 1'b1 && stallCur != 0) ? stallCur : stallLen;
        stallCur <= (cpuStall === 1'b1) ? stallCur + 1 : 0;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic stopTest();
        if (failures == 0 && numChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic resetPulse(input int n);
        @(posedge mclk);
        arstN <= 1'b0;
        repeat (n) @(posedge mclk);
        arstN <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic tRegs();
        u_eac_cpu.rd(`EAC_OFS_SCRATCH0, d);
        chk(d, 8'h00);
        u_eac_cpu.rd(`EAC_OFS_DATA, d);
        chk(d, 8'h00);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h00);
        u_eac_cpu.access(2'h0, 1'b1, `EAC_OFS_SCRATCH1, 8'hA5, d);
        u_eac_cpu.rd(`EAC_OFS_SCRATCH1, d);
        chk(d, 8'hA5);
        u_eac_cpu.wr(`EAC_OFS_SCRATCH0, 8'h5A);
        u_eac_cpu.access(2'h1, 1'b1, `EAC_OFS_SCRATCH0, 8'h00, d);
        chk(d, 8'h5A);
        u_eac_cpu.wr(`EAC_OFS_ADDR_HIGH, 8'hFF);
        u_eac_cpu.rd(`EAC_OFS_ADDR_HIGH, d);
        chk(d, 8'h00);
        u_eac_cpu.wr(`EAC_OFS_CONTROL, 8'hC8);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h08);
        u_eac_cpu.wr(6'h00, 8'h77);
        u_eac_cpu.rd(6'h00, d);
        chk(d, 8'h00);
    endtask

    task automatic tBits();
        u_eac_cpu.wr(`EAC_OFS_SCRATCH1, 8'h81);
        u_eac_cpu.setb(`EAC_OFS_SCRATCH1, 3);
        u_eac_cpu.access(2'h3, 1'b0, `EAC_OFS_SCRATCH1, 8'h00, d);
        u_eac_cpu.access(2'h2, 1'b1, `EAC_OFS_SCRATCH1, 8'h06, d);
        u_eac_cpu.rd(`EAC_OFS_SCRATCH1, d);
        chk(d, 8'h88);
    endtask

    task automatic tArm();
        stallLen = 0;
        u_eac_cpu.setb(`EAC_OFS_CONTROL, `EAC_CR_MPE);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h0C);
        repeat (2) @(posedge mclk);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h08);
        u_eac_cpu.setb(`EAC_OFS_CONTROL, `EAC_CR_PE);
        u_eac_cpu.setb(`EAC_OFS_CONTROL, `EAC_CR_MPE);
        repeat (3) @(posedge mclk);
        u_eac_cpu.setb(`EAC_OFS_CONTROL, `EAC_CR_PE);
        repeat (2) @(posedge mclk);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h08);
        chk(8'(stallLen), 8'h00);
    endtask

    task automatic tModes();
        logic [1:0] m[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [7:0] v[5] = '{8'h3C, 8'h00, 8'h96, 8'h0F, 8'h00};
        logic [7:0] e[5] = '{8'h3C, 8'hFF, 8'h96, 8'h06, 8'h06};
        int t[5] = '{AT, ST, ST, ST, 0};
        int n;
        logic ok;
        chk({7'h00, readyIrq}, 8'h00);
        u_eac_cpu.irq(1'b1);
        repeat (2) @(posedge mclk);
        chk({7'h00, readyIrq}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            stallLen = 0;
            u_eac_cpu.prog(8'h5A, v[i], m[i], i % 3);
            n = 0;
            @(posedge mclk);
            #1;
            while (readyIrq !== 1'b1 && n < 2000) begin
                @(posedge mclk);
                #1;
                n++;
            end
            ok = (t[i] == 0) ? n == 0 : (n <= t[i] * 20 + 2 && n + 20 >= t[i] * 20);
            chk({7'h00, ok}, 8'h01);
            chk(8'(stallLen), t[i] > 0 ? 8'h02 : 8'h00);
            stallLen = 0;
            u_eac_cpu.nvrd(8'h5A, d);
            chk(d, e[i]);
            repeat (5) @(posedge mclk);
            chk(8'(stallLen), 8'h04);
        end
    endtask

    task automatic tBusy();
        u_eac_cpu.prog(8'h22, 8'h11, 2'h0, 0);
        u_eac_cpu.prog(8'h21, 8'hC3, 2'h0, 0);
        u_eac_cpu.wr(`EAC_OFS_ADDR_LOW, 8'h22);
        u_eac_cpu.wr(`EAC_OFS_CONTROL, 8'h28);
        u_eac_cpu.setb(`EAC_OFS_CONTROL, `EAC_CR_RE);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h0A);
        u_eac_cpu.rd(`EAC_OFS_DATA, d);
        chk(d, 8'hC3);
        u_eac_cpu.idle();
        u_eac_cpu.setb(`EAC_OFS_CONTROL, `EAC_CR_RE);
        u_eac_cpu.rd(`EAC_OFS_DATA, d);
        chk(d, 8'hC3);
        u_eac_cpu.nvrd(8'h22, d);
        chk(d, 8'h11);
    endtask

    task automatic tReset();
        u_eac_cpu.wr(`EAC_OFS_CONTROL, 8'h18);
        resetPulse(2);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h00);
        u_eac_cpu.prog(8'h30, 8'h00, 2'h1, 0);
        u_eac_cpu.prog(8'h30, 8'h5C, 2'h2, 0);
        repeat (5) @(posedge mclk);
        resetPulse(3);
        u_eac_cpu.rd(`EAC_OFS_CONTROL, d);
        chk(d, 8'h22);
        u_eac_cpu.nvrd(8'h30, d);
        chk(d, 8'h5C);
    endtask

    initial begin
        arstN = 1'b0;
        porstN = 1'b0;
        repeat (12) @(posedge mclk);
        arstN <= 1'b1;
        porstN <= 1'b1;
        repeat (4) @(posedge mclk);
        tRegs();
        tBits();
        tArm();
        tModes();
        tBusy();
        tReset();
        stopTest();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        stopTest();
    end
endmodule // eac_access_control_tb_top
